// ===== bench/ips_init2_seq_properties.sv
// checker on the phase 2 sequencer word stream and start handling
// bound to the sequencer top; sees only its ports
`timescale 1ns/1ps
module ips_init2_seq_properties
    import ips_pkg::*;
(
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // register port and start
    input wire logic [ips_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_START,
    // word stream and state
    input wire logic O_WORD_VALID,
    input wire logic O_WORD_IS_ID,
    input wire logic O_WORD_PAGE,
    input wire logic [3:0] O_WORD_NIBBLE,
    input wire logic I_WORD_READY,
    input wire logic O_BUSY,
    input wire logic O_DONE
);
    default clocking @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RST_N);
    logic last_id, seen_id, mode_sync;
    logic [4:0] last_addr;
    logic [3:0] rep, k_lim;
    wire hs = O_WORD_VALID && I_WORD_READY;
    wire ctrl_wr = I_WR && (I_ADDR == REG_CTRL);
    wire start_req = I_START || (ctrl_wr && I_WDATA[CTRL_START_BIT]);
    wire [4:0] id_addr = {O_WORD_PAGE, O_WORD_NIBBLE};
    wire same_id = seen_id && (id_addr == last_addr);
    // k follows the mode written before start
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_N)
        begin
            last_id <= 1'b0;
            seen_id <= 1'b0;
            mode_sync <= 1'b0;
            last_addr <= 5'h00;
            rep <= 4'h0;
            k_lim <= 4'h8;
        end
        else
        begin
            if (ctrl_wr)
                mode_sync <= I_WDATA[CTRL_SYNC_BIT];
            if (start_req && !O_BUSY)
                k_lim <= mode_sync ? 4'h4 : 4'h8;
            if (hs)
                last_id <= O_WORD_IS_ID;
            if (hs && O_WORD_IS_ID)
            begin
                seen_id <= 1'b1;
                last_addr <= id_addr;
                rep <= same_id ? rep + 4'h1 : 4'h1;
            end
        end
    end
    property p_start_busy;
        start_req && !O_BUSY |=> O_BUSY && !O_DONE;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not taken");
    property p_done_on_finish;
        $fell(O_BUSY) && $past(I_RST_N) |-> O_DONE;
    endproperty
    a_done_on_finish: assert property (p_done_on_finish) else $error("busy fell, no done");
    property p_done_holds;
        O_DONE && !start_req |=> O_DONE;
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("done dropped");
    property p_idle_quiet;
        !O_BUSY && !O_DONE |-> !O_WORD_VALID;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("word before start");
    property p_id_data_alt;
        hs && seen_id |-> O_WORD_IS_ID != last_id;
    endproperty
    a_id_data_alt: assert property (p_id_data_alt) else $error("id/data not paired");
    property p_data_page;
        hs && !O_WORD_IS_ID && seen_id |-> O_WORD_PAGE == last_addr[4];
    endproperty
    a_data_page: assert property (p_data_page) else $error("data page wrong");
    property p_id_step;
        hs && O_WORD_IS_ID && seen_id |-> (id_addr - last_addr) < 5'h02;
    endproperty
    a_id_step: assert property (p_id_step) else $error("address skipped");
    property p_rep_limit;
        hs && O_WORD_IS_ID && same_id |-> rep < k_lim;
    endproperty
    a_rep_limit: assert property (p_rep_limit) else $error("field repeated too often");
    property p_proto_nib;
        hs && !O_WORD_IS_ID && seen_id && last_addr == 5'h00 |-> O_WORD_NIBBLE == 4'h4;
    endproperty
    a_proto_nib: assert property (p_proto_nib) else $error("protocol nibble wrong");
    property p_stall_hold;
        O_WORD_VALID && !I_WORD_READY |=> O_WORD_VALID
            && $stable({O_WORD_IS_ID, O_WORD_PAGE, O_WORD_NIBBLE});
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("word lost in stall");
    c_start: cover property (start_req && !O_BUSY);
    c_done: cover property ($rose(O_DONE));
    c_stall: cover property ((O_WORD_VALID && !I_WORD_READY) [*3]);
endmodule
bind ips_init2_seq ips_init2_seq_properties chk_u (.*);

// ===== bench/ips_rx_model.sv
// link receiver model with a chosen stall pattern
// assumes the sequencer word port on the same clock
`timescale 1ns/1ps
module ips_rx_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // word port
    input wire logic i_valid,
    input wire logic [5:0] i_word,
    output logic o_ready,
    // stall pattern: 0 none, 1 light, 2 heavy
    input wire logic [1:0] i_stall
);
    logic [5:0] words[$];
    logic [4:0] cnt;
    // heavy stall keeps the buffer full so that slots are refused
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cnt <= 5'h00;
            o_ready <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 5'h01;
            o_ready <= i_stall == 2'h0 || (i_stall == 2'h1 && cnt[1:0] == 2'h0) || cnt == 5'h1F;
            if (i_valid && o_ready)
                words.push_back(i_word);
        end
    end
endmodule

// ===== bench/tb_ips_init2_seq.sv
// self-checking bench for the phase 2 configuration sequencer
// assumes the receiver model and checker are compiled with it
`timescale 1ns/1ps
module tb_ips_init2_seq;
    import ips_pkg::*;
    localparam logic [7:0] PREV = 8'h5A;
    localparam logic [7:0] MAKER = 8'hA5;
    localparam logic [7:0] CFG1 = 8'h90;
    localparam logic [7:0] CFG2 = 8'h3C;
    localparam logic [7:0] CFG6 = 8'h7E;
    localparam logic [7:0] CFG7 = 8'hB3;
    localparam logic [7:0] CFG8 = 8'h6D;
    logic clk, rst_n, wr, rd, start, sync_pin, sync_on, off_done, st_done;
    logic ready, valid, is_id, page, busy, done;
    logic [5:0] addr;
    logic [7:0] wdata, rdata;
    logic [3:0] nib, sync_cnt;
    logic [1:0] stall;
    logic [9:0] off_v, st_v;
    logic [7:0] sn [4];
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    ips_init2_seq #(.SLOT_PERIOD(20), .PROD_REV(PREV)) dut_u (.I_CLK_SYS(clk), .I_RST_N(rst_n),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .I_START(start), .I_SYNC_PIN(sync_pin), .I_SERIAL_BYTE_ZERO(sn[0]),
        .I_SERIAL_BYTE_ONE(sn[1]), .I_SERIAL_BYTE_TWO(sn[2]), .I_SERIAL_BYTE_THREE(sn[3]),
        .I_RAW_OFFSET(off_v), .I_OFFSET_DONE(off_done), .I_AVERAGED_SELFTEST_VALUE(st_v),
        .I_SELFTEST_DONE(st_done), .O_WORD_VALID(valid), .O_WORD_IS_ID(is_id),
        .O_WORD_PAGE(page), .O_WORD_NIBBLE(nib), .I_WORD_READY(ready), .O_BUSY(busy),
        .O_DONE(done));
    ips_rx_model rx_u (.i_clk(clk), .i_rst_n(rst_n), .i_valid(valid),
        .i_word({is_id, page, nib}), .o_ready(ready), .i_stall(stall));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // sync pulses during synchronous runs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        sync_cnt <= sync_cnt + 4'h1;
        sync_pin <= sync_on && sync_cnt < 4'h2;
        if (cycles == 60000)
        begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    function automatic logic [3:0] exp_nib(input int i, input logic [1:0] ax,
        input logic [1:0] rg, input logic ext);
        logic [9:0] o;
        logic [9:0] s;
        logic [7:0] b;
        o = (ext && off_done) ? off_v : 10'h000;
        s = (ext && st_done) ? st_v : 10'h000;
        b = sn[i[2:1] - 2'h1];
        case (i)
            0: return 4'h4;
            1: return 4'h2;
            2, 5: return 4'h0;
            3: return MAKER[7:4];
            4: return MAKER[3:0];
            6: return 4'h1;
            7: return {ax, 2'b00};
            8: return 4'h7 + {2'b00, rg};
            9: return CFG2[7:4];
            10: return CFG2[3:0];
            11: return PREV[7:4];
            12: return PREV[3:0];
            13: return CFG6[3:0];
            14: return CFG7[6:3];
            15: return {CFG7[2:0], CFG7[7]};
            16: return {CFG8[7:5], CFG8[1]};
            17: return CFG8[3:0];
            26: return o[3:0];
            27: return o[7:4];
            28: return {s[1:0], o[9:8]};
            29: return s[5:2];
            30: return s[9:6];
            31: return ext ? CFG1[7:4] : 4'h0;
            default: return i[0] ? b[3:0] : b[7:4];
        endcase
    endfunction
    task automatic run_seq(input logic sync, input logic ext, input logic pin, input logic [1:0] ax,
        input logic [1:0] rg, input logic [1:0] stl, input logic poke);
        int k, f;
        logic [7:0] exp_w;
        k = sync ? 4 : 8;
        rx_u.words.delete();
        stall <= stl;
        wr_reg(REG_AXIS, {4'h0, rg, ax});
        wr_reg(REG_CTRL, {5'h00, ext, sync, 1'b0});
        sync_on <= sync;
        if (pin)
        begin
            @(posedge clk);
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
        end
        else
            wr_reg(REG_CTRL, {5'h00, ext, sync, 1'b1});
        // a start while busy must be ignored
        for (int c = 0; c < 30000 && (done !== 1'b1 || rx_u.words.size() < 64 * k); c++)
        begin
            @(posedge clk);
            start <= poke && c == 3000;
        end
        sync_on <= 1'b0;
        chk("busy", {7'h00, busy}, 8'h00);
        chk("count", {7'h00, rx_u.words.size() == 64 * k}, 8'h01);
        for (int w = 0; w < rx_u.words.size(); w++)
        begin
            f = w / (2 * k);
            exp_w = w[0] ? {3'b000, f >= 16, exp_nib(f, ax, rg, ext)} : {3'b001, f >= 16, f[3:0]};
            chk("word", {2'b00, rx_u.words[w]}, exp_w);
        end
    endtask
    task automatic t_reset_regs;
        logic [7:0] d;
        chk("valid_rst", {7'h00, valid}, 8'h00);
        rd_reg(REG_CFG_ONE, d);
        chk("cfg_one_rst", d, 8'h20);
        rd_reg(6'h3C, d);
        chk("unmapped", d, 8'h00);
        wr_reg(REG_MAKER, MAKER);
        wr_reg(REG_CFG_ONE, CFG1);
        wr_reg(REG_CFG_TWO, CFG2);
        wr_reg(REG_CFG_SIX, CFG6);
        wr_reg(REG_CFG_SEVEN, CFG7);
        wr_reg(REG_CFG_EIGHT, CFG8);
        rd_reg(REG_MAKER, d);
        chk("maker", d, MAKER);
    endtask
    task automatic t_async_full;
        logic [7:0] d;
        run_seq(1'b0, 1'b1, 1'b1, 2'h0, 2'h0, 2'h1, 1'b1);
        rd_reg(REG_STATUS, d);
        chk("status", d & 8'hC0, 8'h80);
    endtask
    task automatic t_sync_partial;
        st_done <= 1'b0;
        off_v <= 10'h3C5;
        run_seq(1'b1, 1'b1, 1'b0, 2'h1, 2'h1, 2'h0, 1'b0);
    endtask
    task automatic t_async_ext_off;
        st_done <= 1'b1;
        run_seq(1'b0, 1'b0, 1'b1, 2'h2, 2'h2, 2'h2, 1'b0);
    endtask
    task automatic t_sync_none_done;
        off_done <= 1'b0;
        st_done <= 1'b0;
        run_seq(1'b1, 1'b1, 1'b1, 2'h1, 2'h3, 2'h1, 1'b0);
    endtask
    initial
    begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        start = 1'b0;
        sync_pin = 1'b0;
        sync_on = 1'b0;
        sync_cnt = 4'h0;
        addr = 6'h00;
        wdata = 8'h00;
        stall = 2'h0;
        off_done = 1'b1;
        st_done = 1'b1;
        off_v = 10'h2B7;
        st_v = 10'h19C;
        sn = '{8'h12, 8'h34, 8'h56, 8'h78};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_regs();
        t_async_full();
        t_sync_partial();
        t_async_ext_off();
        t_sync_none_done();
        end_of_test();
    end
endmodule

// ===== rtl/ips_buf2.sv
// two-entry buffer: a stalled receiver never loses a word
// assumes source and sink on the same clock
`timescale 1ns/1ps
module ips_buf2 #(
    parameter int W = 6
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // filling side
    ips_word_if.snk in_if,
    // draining side
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);
    logic [W-1:0] slot [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    wire push = in_if.valid && in_if.ready;
    wire pop = o_valid && i_ready;

    assign in_if.ready = (count != 2'h2);
    assign o_valid = (count != 2'h0);
    assign o_data = slot[rd_ptr];

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            slot[0] <= '0;
            slot[1] <= '0;
        end
        else
        begin
            if (push)
                slot[wr_ptr] <= in_if.data;
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ===== rtl/ips_init2_seq.sv
// phase 2 configuration sequencer, 10-bit mode: sends 32 tagged nibbles
// assumes a 20 MHz clock, a sync pin from the link and same-clock self-test inputs
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ips_init2_seq
    import ips_pkg::*;
#(
    parameter int SLOT_PERIOD = ips_pkg::SLOT_CYCLES,
    parameter logic [7:0] PROD_REV = 8'h00 // arbitrary factory value
) (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // register port
    input wire logic [ips_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // start of phase 2 and link sync pin
    input wire logic I_START,
    input wire logic I_SYNC_PIN,
    // factory serial number
    input wire logic [7:0] I_SERIAL_BYTE_ZERO,
    input wire logic [7:0] I_SERIAL_BYTE_ONE,
    input wire logic [7:0] I_SERIAL_BYTE_TWO,
    input wire logic [7:0] I_SERIAL_BYTE_THREE,
    // self-test results
    input wire logic [9:0] I_RAW_OFFSET,
    input wire logic I_OFFSET_DONE,
    input wire logic [9:0] I_AVERAGED_SELFTEST_VALUE,
    input wire logic I_SELFTEST_DONE,
    // outgoing words
    output logic O_WORD_VALID,
    output logic O_WORD_IS_ID,
    output logic O_WORD_PAGE,
    output logic [3:0] O_WORD_NIBBLE,
    input wire logic I_WORD_READY,
    // sequence state
    output logic O_BUSY,
    output logic O_DONE
);
    import ips_pkg::*;

    // registers
    logic sync_mode;
    logic extended_init_data_enable;
    logic [7:0] maker_code_field;
    logic [1:0] dir_sel;
    logic [1:0] range_sel;
    logic [7:0] device_config_reg_one;
    logic [7:0] device_config_reg_two;
    logic [7:0] device_config_reg_six;
    logic [7:0] device_config_reg_seven;
    logic [7:0] device_config_reg_eight;
    logic [7:0] rdata;

    // sequencer state
    ips_state_e state;
    ips_state_e next_state;
    logic [4:0] idx;
    logic [3:0] rep;
    logic [3:0] rep_last;
    logic half;

    // sync pin synchroniser
    logic sync_meta;
    logic sync_q;
    logic sync_prev;

    // address decode
    wire sel_ctrl = (I_ADDR == REG_CTRL);
    wire sel_status = (I_ADDR == REG_STATUS);
    wire sel_maker = (I_ADDR == REG_MAKER);
    wire sel_axis = (I_ADDR == REG_AXIS);
    wire sel_one = (I_ADDR == REG_CFG_ONE);
    wire sel_two = (I_ADDR == REG_CFG_TWO);
    wire sel_six = (I_ADDR == REG_CFG_SIX);
    wire sel_seven = (I_ADDR == REG_CFG_SEVEN);
    wire sel_eight = (I_ADDR == REG_CFG_EIGHT);

    wire sw_start = I_WR && sel_ctrl && I_WDATA[CTRL_START_BIT];
    wire start_req = I_START || sw_start;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_N)
        begin
            sync_mode <= 1'b0;
            extended_init_data_enable <= 1'b0;
            maker_code_field <= REG_RST;
            dir_sel <= 2'h0;
            range_sel <= 2'h0;
            device_config_reg_one <= CFG_ONE_RST;
            device_config_reg_two <= REG_RST;
            device_config_reg_six <= REG_RST;
            device_config_reg_seven <= REG_RST;
            device_config_reg_eight <= REG_RST;
        end
        else if (I_WR)
        begin
            if (sel_ctrl)
            begin
                sync_mode <= I_WDATA[CTRL_SYNC_BIT];
                extended_init_data_enable <= I_WDATA[CTRL_EXT_BIT];
            end
            if (sel_maker)
                maker_code_field <= I_WDATA;
            if (sel_axis)
            begin
                dir_sel <= I_WDATA[1:0];
                range_sel <= I_WDATA[3:2];
            end
            if (sel_one)
                device_config_reg_one <= I_WDATA;
            if (sel_two)
                device_config_reg_two <= I_WDATA;
            if (sel_six)
                device_config_reg_six <= I_WDATA;
            if (sel_seven)
                device_config_reg_seven <= I_WDATA;
            if (sel_eight)
                device_config_reg_eight <= I_WDATA;
        end
    end

    // read mux; unmapped offsets read zero
    wire [7:0] ctrl_view = {5'h00, extended_init_data_enable, sync_mode, 1'b0};
    wire [7:0] status_view = {O_DONE, O_BUSY, 1'b0, idx};
    wire [7:0] rd_mux =
        sel_ctrl ? ctrl_view :
        sel_status ? status_view :
        sel_maker ? maker_code_field :
        sel_axis ? {4'h0, range_sel, dir_sel} :
        sel_one ? device_config_reg_one :
        sel_two ? device_config_reg_two :
        sel_six ? device_config_reg_six :
        sel_seven ? device_config_reg_seven :
        sel_eight ? device_config_reg_eight : 8'h00;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_N || !I_RD)
            rdata <= 8'h00;
        else
            rdata <= rd_mux;
    end
    assign O_RDATA = rdata;

    // sync pin: the second flop and its delayed copy in the third feed the edge detector
    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_N)
        begin
            sync_meta <= 1'b0;
            sync_q <= 1'b0;
            sync_prev <= 1'b0;
        end
        else
        begin
            sync_meta <= I_SYNC_PIN;
            sync_q <= sync_meta;
            sync_prev <= sync_q;
        end
    end
    wire sync_edge = sync_q && !sync_prev;

    // internal slot enable, restarted at each start
    logic slot_tick;
    ips_tick #(.PERIOD(SLOT_PERIOD)) u_tick (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_clear(start_req),
        .o_tick(slot_tick)
    );
    wire slot = sync_mode ? sync_edge : slot_tick;

    // julian date fields
    wire [6:0] julian_year = device_config_reg_seven[6:0];
    wire [3:0] julian_month = {device_config_reg_seven[7], device_config_reg_eight[7:5]};
    wire [4:0] julian_day = device_config_reg_eight[4:0];

    wire off_ok = extended_init_data_enable && I_OFFSET_DONE;
    wire st_ok = extended_init_data_enable && I_SELFTEST_DONE;
    wire [9:0] off_v = off_ok ? I_RAW_OFFSET : 10'h000;
    wire [9:0] st_v = st_ok ? I_AVERAGED_SELFTEST_VALUE : 10'h000;

    // serial nibble select, high nibble first
    wire [4:0] sn_pos = idx - IDX_SN_FIRST;
    wire [7:0] sn_byte =
        (sn_pos[2:1] == 2'h0) ? I_SERIAL_BYTE_ZERO :
        (sn_pos[2:1] == 2'h1) ? I_SERIAL_BYTE_ONE :
        (sn_pos[2:1] == 2'h2) ? I_SERIAL_BYTE_TWO : I_SERIAL_BYTE_THREE;
    wire [3:0] sn_nib = sn_pos[0] ? sn_byte[3:0] : sn_byte[7:4];

    wire [3:0] axis_nib =
        (dir_sel == 2'h0) ? NIB_AXIS_0 :
        (dir_sel == 2'h1) ? NIB_AXIS_1 :
        (dir_sel == 2'h2) ? NIB_AXIS_2 : NIB_AXIS_3;
    wire [3:0] range_nib =
        (range_sel == 2'h0) ? NIB_RANGE_60 :
        (range_sel == 2'h1) ? NIB_RANGE_120 :
        (range_sel == 2'h2) ? NIB_RANGE_240 : NIB_RANGE_480;

    function automatic logic [3:0] pick(input logic [4:0] i);
        logic [3:0] n;
        n = NIB_ZERO;
        case (i)
            IDX_PROTO: n = NIB_PROTO;
            IDX_BLK_HI: n = NIB_BLK_HI;
            IDX_BLK_LO: n = NIB_BLK_LO;
            IDX_MAKER_HI: n = maker_code_field[7:4];
            IDX_MAKER_LO: n = maker_code_field[3:0];
            IDX_TYPE_HI: n = NIB_TYPE_HI;
            IDX_TYPE_LO: n = NIB_TYPE_LO;
            IDX_AXIS: n = axis_nib;
            IDX_RANGE: n = range_nib;
            IDX_CFG2_HI: n = device_config_reg_two[7:4];
            IDX_CFG2_LO: n = device_config_reg_two[3:0];
            IDX_PREV_HI: n = PROD_REV[7:4];
            IDX_PREV_LO: n = PROD_REV[3:0];
            IDX_CFG6: n = device_config_reg_six[3:0];
            IDX_DATE0: n = julian_year[6:3];
            IDX_DATE1: n = {julian_year[2:0], julian_month[3]};
            IDX_DATE2: n = {julian_month[2:0], julian_day[1]};
            IDX_DATE3: n = julian_day[3:0];
            IDX_OFF_LO: n = off_v[3:0];
            IDX_OFF_MID: n = off_v[7:4];
            IDX_OFF_ST: n = {st_v[1:0], off_v[9:8]};
            IDX_ST_MID: n = st_v[5:2];
            IDX_ST_HI: n = st_v[9:6];
            IDX_CFG1: n = extended_init_data_enable ? device_config_reg_one[7:4] : NIB_ZERO;
            default:
            begin
                if (i >= IDX_SN_FIRST && i <= IDX_SN_LAST)
                    n = sn_nib;
            end
        endcase
        return n;
    endfunction

    wire [3:0] data_nib = pick(idx);
    // page moves after the sixteenth nibble
    wire page = idx[4];

    // buffer toward the link transmitter
    ips_word_if #(.W(WORD_W)) word_if ();
    wire push_ok = word_if.valid && word_if.ready;
    assign word_if.valid = (state == ST_PUSH);
    assign word_if.data = {~half, page, half ? data_nib : idx[3:0]};

    logic [WORD_W-1:0] out_word;
    ips_buf2 #(.W(WORD_W)) u_buf (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .in_if(word_if),
        .o_valid(O_WORD_VALID),
        .o_data(out_word),
        .i_ready(I_WORD_READY)
    );
    assign O_WORD_IS_ID = out_word[5];
    assign O_WORD_PAGE = out_word[4];
    assign O_WORD_NIBBLE = out_word[3:0];

    wire last_rep = (rep == rep_last);
    wire last_word = half && last_rep && (idx == IDX_LAST);

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (start_req)
                    next_state = ST_WAIT;
            ST_WAIT:
                if (slot)
                    next_state = ST_PUSH;
            ST_PUSH:
                if (push_ok)
                    next_state = last_word ? ST_DONE : ST_WAIT;
            ST_DONE:
                if (start_req)
                    next_state = ST_WAIT;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RST_N)
        begin
            state <= ST_IDLE;
            idx <= 5'h00;
            rep <= 4'h0;
            rep_last <= REP_ASYNC - 4'h1;
            half <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (start_req && (state == ST_IDLE || state == ST_DONE))
            begin
                idx <= 5'h00;
                rep <= 4'h0;
                half <= 1'b0;
                rep_last <= (sync_mode ? REP_SYNC : REP_ASYNC) - 4'h1;
            end
            else if (push_ok)
            begin
                half <= ~half;
                if (half)
                begin
                    rep <= last_rep ? 4'h0 : rep + 4'h1;
                    if (last_rep && idx != IDX_LAST)
                        idx <= idx + 5'h01;
                end
            end
        end
    end

    assign O_BUSY = (state == ST_WAIT) || (state == ST_PUSH);
    assign O_DONE = (state == ST_DONE);
endmodule

// ===== rtl/ips_pkg.sv
// constants shared by the phase 2 sequencer and its helpers
// assumes a 20 MHz system clock and 8-bit register writes
package ips_pkg;
    // clock and transmit slot timing
    localparam int CLK_KHZ = 20000;
    localparam int SLOT_US = 228;
    localparam int SLOT_CYCLES = (SLOT_US * CLK_KHZ) / 1000;
    // sequence shape
    localparam int NIBBLE_COUNT = 32;
    localparam logic [4:0] IDX_LAST = 5'h1F;
    localparam logic [3:0] REP_ASYNC = 4'h8;
    localparam logic [3:0] REP_SYNC = 4'h4;
    // nibble positions, zero based (D1 sits at 0)
    localparam logic [4:0] IDX_PROTO = 5'h00;
    localparam logic [4:0] IDX_BLK_HI = 5'h01;
    localparam logic [4:0] IDX_BLK_LO = 5'h02;
    localparam logic [4:0] IDX_MAKER_HI = 5'h03;
    localparam logic [4:0] IDX_MAKER_LO = 5'h04;
    localparam logic [4:0] IDX_TYPE_HI = 5'h05;
    localparam logic [4:0] IDX_TYPE_LO = 5'h06;
    localparam logic [4:0] IDX_AXIS = 5'h07;
    localparam logic [4:0] IDX_RANGE = 5'h08;
    localparam logic [4:0] IDX_CFG2_HI = 5'h09;
    localparam logic [4:0] IDX_CFG2_LO = 5'h0A;
    localparam logic [4:0] IDX_PREV_HI = 5'h0B;
    localparam logic [4:0] IDX_PREV_LO = 5'h0C;
    localparam logic [4:0] IDX_CFG6 = 5'h0D;
    localparam logic [4:0] IDX_DATE0 = 5'h0E;
    localparam logic [4:0] IDX_DATE1 = 5'h0F;
    localparam logic [4:0] IDX_DATE2 = 5'h10;
    localparam logic [4:0] IDX_DATE3 = 5'h11;
    localparam logic [4:0] IDX_SN_FIRST = 5'h12;
    localparam logic [4:0] IDX_SN_LAST = 5'h19;
    localparam logic [4:0] IDX_OFF_LO = 5'h1A;
    localparam logic [4:0] IDX_OFF_MID = 5'h1B;
    localparam logic [4:0] IDX_OFF_ST = 5'h1C;
    localparam logic [4:0] IDX_ST_MID = 5'h1D;
    localparam logic [4:0] IDX_ST_HI = 5'h1E;
    localparam logic [4:0] IDX_CFG1 = 5'h1F;
    // fixed nibble values
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [3:0] NIB_PROTO = 4'h4;
    localparam logic [3:0] NIB_BLK_HI = 4'h2;
    localparam logic [3:0] NIB_BLK_LO = 4'h0;
    localparam logic [3:0] NIB_TYPE_HI = 4'h0;
    localparam logic [3:0] NIB_TYPE_LO = 4'h1;
    localparam logic [3:0] NIB_AXIS_0 = 4'h0;
    localparam logic [3:0] NIB_AXIS_1 = 4'h4;
    localparam logic [3:0] NIB_AXIS_2 = 4'h8;
    localparam logic [3:0] NIB_AXIS_3 = 4'hC;
    localparam logic [3:0] NIB_RANGE_60 = 4'h7;
    localparam logic [3:0] NIB_RANGE_120 = 4'h8;
    localparam logic [3:0] NIB_RANGE_240 = 4'h9;
    localparam logic [3:0] NIB_RANGE_480 = 4'hA;
    // register port
    localparam int ADDR_W = 6;
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STATUS = 6'h04;
    localparam logic [5:0] REG_MAKER = 6'h08;
    localparam logic [5:0] REG_AXIS = 6'h0C;
    localparam logic [5:0] REG_CFG_ONE = 6'h10;
    localparam logic [5:0] REG_CFG_TWO = 6'h14;
    localparam logic [5:0] REG_CFG_SIX = 6'h18;
    localparam logic [5:0] REG_CFG_SEVEN = 6'h1C;
    localparam logic [5:0] REG_CFG_EIGHT = 6'h20;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SYNC_BIT = 1;
    localparam int CTRL_EXT_BIT = 2;
    localparam logic [7:0] CFG_ONE_RST = 8'h20;
    localparam logic [7:0] REG_RST = 8'h00;
    // outgoing word: {is_id, page, nibble}
    localparam int WORD_W = 6;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PUSH, ST_DONE} ips_state_e;
endpackage

// ===== rtl/ips_tick.sv
// free running divider giving a one-cycle slot enable
// assumes i_clear is a same-clock level or pulse
`timescale 1ns/1ps
module ips_tick #(
    parameter int PERIOD = 4560
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // control and enable
    input wire logic i_clear,
    output logic o_tick
);
    localparam int CW = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    logic [CW-1:0] count;
    wire at_end = (count == LAST);

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || i_clear || at_end)
            count <= '0;
        else
            count <= count + 1'b1;
    end

    assign o_tick = at_end && !i_clear;
endmodule

// ===== rtl/ips_word_if.sv
// handshake carrier between the sequencer and its output buffer
// assumes both ends sit on the system clock
`timescale 1ns/1ps
interface ips_word_if #(parameter int W = 6);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
